// ==== core/tx_fifo_defs.svh ====
// constants of the transmit frame fifo: register offsets, field positions, resets
// assumes an 8-bit, byte-addressed register port with 16-bit addresses
`ifndef TX_FIFO_DEFS_SVH
`define TX_FIFO_DEFS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define ADDR_PUSH_DATA     16'h2000
`define ADDR_WR_PTR_LOW    16'h2001
`define ADDR_RD_PTR_LOW    16'h2002
`define ADDR_CONTROL       16'h2003
`define ADDR_STATE         16'h2004
`define ADDR_BYTE_COUNT    16'h2005
`define ADDR_REMAINING     16'h2006
`define ADDR_ENC_START     16'h2007
`define ADDR_ENC_LENGTH    16'h2008
`define ADDR_CIPHER_CTRL   16'h218E

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CTL_CLEAR_BIT      0
`define CTL_ENABLE_BIT     1
`define CTL_AUTO_SETUP_BIT 2
`define STS_EMPTY_BIT      0
`define STS_FULL_BIT       1
`define STS_RD_TOP_BIT     6
`define STS_WR_TOP_BIT     7
`define CIPHER_START_BIT   0
`define CIPHER_KEY_BIT     1
`define CIPHER_DIR_BIT     2

// ------------------------------------------------------------
// reset values and sizes
// ------------------------------------------------------------
`define RST_ENABLE         1'b1
`define RST_AUTO_SETUP     1'b1
`define RST_BYTE           8'h00
`define RST_PTR            9'h000
`define FIFO_DEPTH         256
`define PTR_ONE            9'h001
`define BYTE_ONE           8'h01

`endif

// ==== core/tx_fifo_pkg.sv ====
// types shared by the transmit frame fifo and its surroundings
// assumes nothing from tx_fifo_defs.svh; its widths and state codes are literal
package tx_fifo_pkg;

    // register port request from the processor
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } reg_req_t;

    // push request from the transmit dma channel
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } dma_push_t;

    // byte fetch from the transmit controller
    typedef struct packed {
        logic [8:0] ptr;
        logic       pop;
    } tx_fetch_t;

    // packet frame information for auto cipher setup
    typedef struct packed {
        logic       load;
        logic [7:0] start;
        logic [7:0] length;
    } frame_info_t;

    // cipher selection presented to the aes engine
    typedef struct packed {
        logic       encrypt_go;
        logic       decrypt_go;
        logic       standalone_go;
        logic       key_sel;
        logic       use_tx_nonce;
        logic [7:0] start;
        logic [7:0] length;
    } cipher_cmd_t;

    typedef enum logic [1:0] {
        CIPHER_IDLE = 2'b00,
        CIPHER_BUSY = 2'b01,
        CIPHER_DONE = 2'b11
    } cipher_state_t;

endpackage : tx_fifo_pkg

// ==== core/tx_frame_fifo.sv ====
// transmit frame fifo with pointer, status and encryption window registers
// assumes an 8-bit processor register port, a dma push port, a transmit
// controller reading bytes, and an aes engine that reports completion
`timescale 1ns/1ps
`include "tx_fifo_defs.svh"

// How it works
// [R1] two 128-bit keys kept; every cipher operation uses the selected key
// [R2] encryption uses the transmit nonce with the selected key
// [R3] decryption uses the receive nonce with the selected key
// [R4] standalone cipher started from its control register, operand buffer, selected key
// [R5] each push register write stores the byte at the write position while the fifo is enabled and not full
// [R6] fifo holds 256 bytes, written by processor or transmit dma
// [R7] 9-bit write pointer, low byte register, top bit in status, steps per write
// [R8] 9-bit read pointer, split likewise, steps per byte read out
// [R9] status bit 7 write top bit, bit 6 read top bit, both writable
// [R10] control bit 1 enables the fifo, resets to one
// [R11] control bit 0 clears pointers, status, size and remaining count
// [R12] status bit 1 set exactly when 256 bytes held
// [R13] status bit 0 set exactly when no bytes held
// [R14] size register is write pointer minus read pointer
// [R15] encryption start writable, auto loaded with packet start
// [R16] encryption length writable, auto loaded with packet length
// [R17] control bit 2 enables auto loading, resets to one
// [R18] completed encryption raises the cipher completion interrupt
// [R19] software puts frame length in first byte; device rewrites it after encryption
// [R20] full when low bits match and top bits differ; empty when all match
module tx_frame_fifo (
    // clock and reset
    input  wire logic                       CLK_SYS_IN,
    input  wire logic                       RESET_IN,
    // processor register port
    input  wire tx_fifo_pkg::reg_req_t      REG_REQ_IN,
    output logic [7:0]                      REG_RDATA_OUT,
    // transmit dma channel
    input  wire tx_fifo_pkg::dma_push_t     DMA_PUSH_IN,
    output logic                            DMA_READY_OUT,
    // transmit controller byte fetch
    input  wire tx_fifo_pkg::tx_fetch_t     TX_FETCH_IN,
    output logic [7:0]                      TX_DATA_OUT,
    // frame information and cipher engine
    input  wire tx_fifo_pkg::frame_info_t   FRAME_INFO_IN,
    input  wire logic [127:0]               FIRST_KEY_IN,
    input  wire logic [127:0]               SECOND_KEY_IN,
    input  wire logic [127:0]               TX_NONCE_IN,
    input  wire logic [127:0]               RX_NONCE_IN,
    input  wire logic                       CIPHER_DONE_IN,
    input  wire logic                       LEN_REWRITE_IN,
    input  wire logic [7:0]                 LEN_REWRITE_DATA_IN,
    output tx_fifo_pkg::cipher_cmd_t        CIPHER_CMD_OUT,
    output logic [127:0]                    CIPHER_KEY_OUT,
    output logic [127:0]                    CIPHER_NONCE_OUT,
    output logic                            CIPHER_IRQ_OUT
);
    import tx_fifo_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [8:0]    wr_ptr;
        logic [8:0]    rd_ptr;
        logic          enable;
        logic          auto_setup;
        logic          clear;
        logic [7:0]    enc_start;
        logic [7:0]    enc_length;
        logic [7:0]    remaining;
        logic [7:0]    rdata;
        logic [7:0]    tx_data;
        logic          key_sel;
        logic          decrypt;
        cipher_state_t cstate;
        logic          standalone;
        cipher_cmd_t   cmd;
        logic          irq;
    } state_t;

    state_t     st_ff;
    state_t     nxt_st;
    logic [7:0] mem_ff [0:`FIFO_DEPTH-1];

    logic       full;
    logic       empty;
    logic [8:0] used;
    logic       cpu_push;
    logic       push;
    logic       pop;
    logic [7:0] push_data;
    logic [7:0] ctl_rd;
    logic [7:0] sts_rd;

    // ------------------------------------------------------------
    // occupancy
    // ------------------------------------------------------------
    assign full  = (st_ff.wr_ptr[7:0] == st_ff.rd_ptr[7:0])
                 && (st_ff.wr_ptr[8] != st_ff.rd_ptr[8]);           // [R20] [R12]
    assign empty = (st_ff.wr_ptr == st_ff.rd_ptr);                  // [R20] [R13]
    assign used  = st_ff.wr_ptr - st_ff.rd_ptr;                     // [R14]

    // processor push wins over the dma in the same cycle; dma is held off
    assign cpu_push      = REG_REQ_IN.wr && (REG_REQ_IN.addr == `ADDR_PUSH_DATA);
    assign DMA_READY_OUT = st_ff.enable && !full && !cpu_push;      // [R6]
    assign push          = st_ff.enable && !full
                         && (cpu_push || DMA_PUSH_IN.valid);        // [R5] [R6]
    assign push_data     = cpu_push ? REG_REQ_IN.wdata : DMA_PUSH_IN.data;
    assign pop           = st_ff.enable && !empty && TX_FETCH_IN.pop;

    always_comb begin
        ctl_rd = `RST_BYTE;
        ctl_rd[`CTL_CLEAR_BIT]      = st_ff.clear;
        ctl_rd[`CTL_ENABLE_BIT]     = st_ff.enable;
        ctl_rd[`CTL_AUTO_SETUP_BIT] = st_ff.auto_setup;
        sts_rd = `RST_BYTE;
        sts_rd[`STS_WR_TOP_BIT] = st_ff.wr_ptr[8];                  // [R9]
        sts_rd[`STS_RD_TOP_BIT] = st_ff.rd_ptr[8];                  // [R9]
        sts_rd[`STS_FULL_BIT]   = full;                             // [R12]
        sts_rd[`STS_EMPTY_BIT]  = empty;                            // [R13]
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.cmd.encrypt_go    = 1'b0;
        nxt_st.cmd.decrypt_go    = 1'b0;
        nxt_st.cmd.standalone_go = 1'b0;
        nxt_st.irq               = 1'b0;
        nxt_st.clear             = 1'b0;

        if (push) begin
            nxt_st.wr_ptr = st_ff.wr_ptr + `PTR_ONE;                // [R7]
        end
        if (pop) begin
            nxt_st.rd_ptr = st_ff.rd_ptr + `PTR_ONE;                // [R8]
            if (st_ff.remaining != `RST_BYTE) begin
                nxt_st.remaining = st_ff.remaining - `BYTE_ONE;
            end
        end
        nxt_st.tx_data = mem_ff[TX_FETCH_IN.ptr[7:0]];

        if (st_ff.auto_setup && FRAME_INFO_IN.load) begin
            nxt_st.enc_start  = FRAME_INFO_IN.start;                // [R15] [R17]
            nxt_st.enc_length = FRAME_INFO_IN.length;               // [R16] [R17]
            nxt_st.remaining  = FRAME_INFO_IN.length;
        end

        nxt_st.rdata = `RST_BYTE;
        if (REG_REQ_IN.rd) begin
            unique case (REG_REQ_IN.addr)
                `ADDR_WR_PTR_LOW:  nxt_st.rdata = st_ff.wr_ptr[7:0];
                `ADDR_RD_PTR_LOW:  nxt_st.rdata = st_ff.rd_ptr[7:0];
                `ADDR_CONTROL:     nxt_st.rdata = ctl_rd;
                `ADDR_STATE:       nxt_st.rdata = sts_rd;
                `ADDR_BYTE_COUNT:  nxt_st.rdata = used[7:0];        // [R14]
                `ADDR_REMAINING:   nxt_st.rdata = st_ff.remaining;
                `ADDR_ENC_START:   nxt_st.rdata = st_ff.enc_start;
                `ADDR_ENC_LENGTH:  nxt_st.rdata = st_ff.enc_length;
                `ADDR_CIPHER_CTRL: begin
                    nxt_st.rdata[`CIPHER_KEY_BIT]   = st_ff.key_sel;
                    nxt_st.rdata[`CIPHER_DIR_BIT]   = st_ff.decrypt;
                    nxt_st.rdata[`CIPHER_START_BIT] = (st_ff.cstate != CIPHER_IDLE);
                end
                default:           nxt_st.rdata = `RST_BYTE;
            endcase
        end

        if (REG_REQ_IN.wr) begin
            unique case (REG_REQ_IN.addr)
                `ADDR_WR_PTR_LOW:  nxt_st.wr_ptr[7:0] = REG_REQ_IN.wdata;
                `ADDR_RD_PTR_LOW:  nxt_st.rd_ptr[7:0] = REG_REQ_IN.wdata;
                `ADDR_CONTROL: begin
                    nxt_st.enable     = REG_REQ_IN.wdata[`CTL_ENABLE_BIT];     // [R10]
                    nxt_st.auto_setup = REG_REQ_IN.wdata[`CTL_AUTO_SETUP_BIT]; // [R17]
                    nxt_st.clear      = REG_REQ_IN.wdata[`CTL_CLEAR_BIT];
                end
                `ADDR_STATE: begin
                    nxt_st.wr_ptr[8] = REG_REQ_IN.wdata[`STS_WR_TOP_BIT];      // [R9]
                    nxt_st.rd_ptr[8] = REG_REQ_IN.wdata[`STS_RD_TOP_BIT];      // [R9]
                end
                `ADDR_ENC_START:   nxt_st.enc_start  = REG_REQ_IN.wdata;       // [R15]
                `ADDR_ENC_LENGTH:  nxt_st.enc_length = REG_REQ_IN.wdata;       // [R16]
                `ADDR_CIPHER_CTRL: begin
                    nxt_st.key_sel = REG_REQ_IN.wdata[`CIPHER_KEY_BIT];        // [R1]
                    nxt_st.decrypt = REG_REQ_IN.wdata[`CIPHER_DIR_BIT];
                    if (REG_REQ_IN.wdata[`CIPHER_START_BIT]
                        && st_ff.cstate == CIPHER_IDLE) begin
                        nxt_st.standalone        = 1'b1;
                        nxt_st.cmd.standalone_go = 1'b1;                       // [R4]
                        nxt_st.cstate            = CIPHER_BUSY;
                    end
                end
                default: ;
            endcase
        end

        // window encryption of the fifo runs on a start with the direction bit clear
        if (nxt_st.cmd.standalone_go) begin
            nxt_st.standalone        = !st_ff.decrypt ? 1'b0 : 1'b1;
            nxt_st.cmd.encrypt_go    = !REG_REQ_IN.wdata[`CIPHER_DIR_BIT];     // [R2]
            nxt_st.cmd.decrypt_go    = 1'b0;
            nxt_st.cmd.standalone_go = 1'b0;
            if (REG_REQ_IN.wdata[`CIPHER_DIR_BIT]) begin
                nxt_st.cmd.standalone_go = 1'b1;                               // [R4]
            end
        end

        unique case (st_ff.cstate)
            CIPHER_IDLE: ;
            CIPHER_BUSY: begin
                if (CIPHER_DONE_IN) begin
                    nxt_st.cstate = CIPHER_DONE;
                end
            end
            CIPHER_DONE: begin
                nxt_st.irq    = 1'b1;                                          // [R18]
                nxt_st.cstate = CIPHER_IDLE;
            end
            default: nxt_st.cstate = CIPHER_IDLE;
        endcase

        nxt_st.cmd.key_sel      = nxt_st.key_sel;                              // [R1]
        nxt_st.cmd.use_tx_nonce = !nxt_st.decrypt;                             // [R2] [R3]
        nxt_st.cmd.start        = nxt_st.enc_start;
        nxt_st.cmd.length       = nxt_st.enc_length;

        if (REG_REQ_IN.wr && REG_REQ_IN.addr == `ADDR_CONTROL
            && REG_REQ_IN.wdata[`CTL_CLEAR_BIT]) begin
            nxt_st.wr_ptr    = `RST_PTR;                                       // [R11]
            nxt_st.rd_ptr    = `RST_PTR;                                       // [R11]
            nxt_st.remaining = `RST_BYTE;                                      // [R11]
        end
    end

    // ------------------------------------------------------------
    // registers and storage
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            st_ff            <= '0;
            st_ff.enable     <= `RST_ENABLE;                                   // [R10]
            st_ff.auto_setup <= `RST_AUTO_SETUP;                               // [R17]
            st_ff.cstate     <= CIPHER_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // length byte rewritten at the window start whenever LEN_REWRITE_IN is high; a push in the same cycle takes precedence
    always_ff @(posedge CLK_SYS_IN) begin
        if (push) begin
            mem_ff[st_ff.wr_ptr[7:0]] <= push_data;                            // [R5]
        end else if (LEN_REWRITE_IN) begin
            mem_ff[st_ff.enc_start] <= LEN_REWRITE_DATA_IN;                    // [R19]
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign REG_RDATA_OUT    = st_ff.rdata;
    assign TX_DATA_OUT      = st_ff.tx_data;
    assign CIPHER_CMD_OUT   = st_ff.cmd;
    assign CIPHER_KEY_OUT   = st_ff.key_sel ? SECOND_KEY_IN : FIRST_KEY_IN;    // [R1]
    assign CIPHER_NONCE_OUT = st_ff.decrypt ? RX_NONCE_IN : TX_NONCE_IN;       // [R2] [R3]
    assign CIPHER_IRQ_OUT   = st_ff.irq;                                       // [R18]

endmodule : tx_frame_fifo

// ==== sim/aes_engine_model.sv ====
// aes engine stand-in: answers a go pulse with one done pulse unless delay_in is zero or another go arrives first
// assumes the cipher command struct of tx_fifo_pkg
`timescale 1ns/1ps
module aes_engine_model (
    // clock and reset
    input  wire logic                     clk_in,
    input  wire logic                     reset_in,
    // command in, completion out
    input  wire tx_fifo_pkg::cipher_cmd_t cmd_in,
    input  wire logic [7:0]               delay_in,
    output logic                          done_out
);
    import tx_fifo_pkg::*;
    logic [7:0] count_ff;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            count_ff <= 8'h00;
        end else if (cmd_in.encrypt_go || cmd_in.decrypt_go || cmd_in.standalone_go) begin
            count_ff <= delay_in;
        end else if (count_ff != 8'h00) begin
            count_ff <= count_ff - 8'h01;
        end
    end
    // delay_in sets a prompt or a slow answer
    assign done_out = (count_ff == 8'h01);
endmodule : aes_engine_model

// ==== sim/tx_fifo_properties.sv ====
// port checker of the transmit frame fifo
// assumes it is bound into tx_frame_fifo
`timescale 1ns/1ps
`include "tx_fifo_defs.svh"
module tx_fifo_properties (
    input wire logic                     CLK_SYS_IN,
    input wire logic                     RESET_IN,
    input wire tx_fifo_pkg::reg_req_t    REG_REQ_IN,
    input wire logic                     DMA_READY_OUT,
    input wire logic [127:0]             FIRST_KEY_IN,
    input wire logic [127:0]             SECOND_KEY_IN,
    input wire logic [127:0]             TX_NONCE_IN,
    input wire logic                     CIPHER_DONE_IN,
    input wire tx_fifo_pkg::cipher_cmd_t CIPHER_CMD_OUT,
    input wire logic [127:0]             CIPHER_KEY_OUT,
    input wire logic [127:0]             CIPHER_NONCE_OUT,
    input wire logic                     CIPHER_IRQ_OUT
);
    import tx_fifo_pkg::*;
    logic ctl_wr;
    logic enc_req;
    logic solo_req;
    logic key_req;
    logic push_wr;
    assign ctl_wr = REG_REQ_IN.wr && REG_REQ_IN.addr == `ADDR_CIPHER_CTRL && REG_REQ_IN.wdata[0];
    assign enc_req = ctl_wr && !REG_REQ_IN.wdata[2];
    assign solo_req = ctl_wr && REG_REQ_IN.wdata[2];
    assign key_req = REG_REQ_IN.wdata[1];
    assign push_wr = REG_REQ_IN.wr && REG_REQ_IN.addr == `ADDR_PUSH_DATA;
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (RESET_IN);
    a_push_blocks_dma: assert property (push_wr |-> !DMA_READY_OUT)
        else $error("dma ready during processor push");
    a_key_follows_sel: assert property (
        CIPHER_KEY_OUT == (CIPHER_CMD_OUT.key_sel ? SECOND_KEY_IN : FIRST_KEY_IN))
        else $error("cipher key not the selected one");
    a_encrypt_tx_nonce: assert property (
        CIPHER_CMD_OUT.encrypt_go |-> CIPHER_NONCE_OUT == TX_NONCE_IN)
        else $error("encryption without transmit nonce");
    a_encrypt_go_cause: assert property (CIPHER_CMD_OUT.encrypt_go |-> $past(enc_req))
        else $error("encrypt go without start write");
    a_solo_go_cause: assert property (CIPHER_CMD_OUT.standalone_go |-> $past(solo_req))
        else $error("standalone go without start write");
    a_key_latch: assert property (
        CIPHER_CMD_OUT.encrypt_go |-> CIPHER_CMD_OUT.key_sel == $past(key_req))
        else $error("key select not taken from start write");
    a_irq_after_done: assert property (CIPHER_DONE_IN |-> ##2 CIPHER_IRQ_OUT)
        else $error("no interrupt two cycles after done");
    a_irq_needs_done: assert property (CIPHER_IRQ_OUT |-> $past(CIPHER_DONE_IN, 2))
        else $error("interrupt without done");
endmodule : tx_fifo_properties

bind tx_frame_fifo tx_fifo_properties tx_fifo_properties_i (
    .CLK_SYS_IN(CLK_SYS_IN), .RESET_IN(RESET_IN), .REG_REQ_IN(REG_REQ_IN),
    .DMA_READY_OUT(DMA_READY_OUT), .FIRST_KEY_IN(FIRST_KEY_IN),
    .SECOND_KEY_IN(SECOND_KEY_IN), .TX_NONCE_IN(TX_NONCE_IN),
    .CIPHER_DONE_IN(CIPHER_DONE_IN), .CIPHER_CMD_OUT(CIPHER_CMD_OUT),
    .CIPHER_KEY_OUT(CIPHER_KEY_OUT), .CIPHER_NONCE_OUT(CIPHER_NONCE_OUT),
    .CIPHER_IRQ_OUT(CIPHER_IRQ_OUT));

// ==== sim/tx_frame_fifo_tb.sv ====
// self-checking bench of the transmit frame fifo
// assumes the aes engine stand-in and the port checker are compiled first
`timescale 1ns/1ps
`include "tx_fifo_defs.svh"
module tx_frame_fifo_tb;
    import tx_fifo_pkg::*;
    localparam logic [127:0] KEY_A = 128'h0123456789ABCDEF0123456789ABCDEF;
    localparam logic [127:0] KEY_B = 128'hFEDCBA9876543210FEDCBA9876543210;
    localparam logic [127:0] NON_T = 128'h11112222333344445555666677778888;
    localparam logic [127:0] NON_R = 128'h9999AAAABBBBCCCCDDDDEEEEFFFF0000;
    logic          clk;
    logic          rst;
    reg_req_t      req;
    logic [7:0]    rdata;
    dma_push_t     dma;
    logic          dma_ready;
    tx_fetch_t     fet;
    logic [7:0]    tx_data;
    frame_info_t   frm;
    logic          done;
    logic          rew;
    logic [7:0]    rew_data;
    cipher_cmd_t   cmd;
    logic [127:0]  key;
    logic [127:0]  nonce;
    logic          irq;
    logic [7:0]    delay;
    int            bad_count = 0;
    int            compares = 0;
    tx_frame_fifo tx_frame_fifo_i (.CLK_SYS_IN(clk), .RESET_IN(rst), .REG_REQ_IN(req),
        .REG_RDATA_OUT(rdata), .DMA_PUSH_IN(dma), .DMA_READY_OUT(dma_ready),
        .TX_FETCH_IN(fet), .TX_DATA_OUT(tx_data), .FRAME_INFO_IN(frm),
        .FIRST_KEY_IN(KEY_A), .SECOND_KEY_IN(KEY_B), .TX_NONCE_IN(NON_T),
        .RX_NONCE_IN(NON_R), .CIPHER_DONE_IN(done), .LEN_REWRITE_IN(rew),
        .LEN_REWRITE_DATA_IN(rew_data), .CIPHER_CMD_OUT(cmd), .CIPHER_KEY_OUT(key),
        .CIPHER_NONCE_OUT(nonce), .CIPHER_IRQ_OUT(irq));
    aes_engine_model aes_engine_model_i (.clk_in(clk), .reset_in(rst), .cmd_in(cmd),
        .delay_in(delay), .done_out(done));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic conclude();
        if (bad_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude
    task automatic check(input string name, input logic [127:0] seen, input logic [127:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        #1 req = '0;
    endtask : reg_wr
    task automatic reg_rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        #1 req = '0;
        check($sformatf("reg %h", a), rdata, exp);
    endtask : reg_rd
    task automatic fetch(input logic [8:0] p, input logic pop, input logic [7:0] exp);
        @(posedge clk);
        #1 fet = '{ptr: p, pop: pop};
        @(posedge clk);
        #1 fet = '0;
        check("fetched byte", tx_data, exp);
    endtask : fetch
    task automatic dma_push(input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        #1 dma = '{valid: 1'b1, data: d};
        while (dma_ready !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1 n++;
        end
        @(posedge clk);
        #1 dma = '0;
        check("dma ready wait", n < 20, 1'b1);
    endtask : dma_push
    task automatic frame_load(input logic [7:0] s, input logic [7:0] l);
        @(posedge clk);
        #1 frm = '{load: 1'b1, start: s, length: l};
        @(posedge clk);
        #1 frm = '0;
    endtask : frame_load
    task automatic cipher(input logic [7:0] c, input logic [127:0] k, input logic [127:0] nn);
        int n;
        n = 0;
        reg_wr(`ADDR_CIPHER_CTRL, c);
        check("cipher key", key, k);
        check("cipher nonce", nonce, nn);
        while (irq !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1 n++;
        end
        check("cipher irq", irq, 1'b1);
    endtask : cipher
    initial begin
        #200000;
        bad_count++;
        conclude();
    end
    initial begin
        req = '0;
        dma = '0;
        fet = '0;
        frm = '0;
        rew = 1'b0;
        rew_data = 8'h00;
        delay = 8'h01;
        rst = 1'b1;
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        reg_rd(`ADDR_CONTROL, 8'h06);
        reg_rd(`ADDR_STATE, 8'h01);
        reg_rd(`ADDR_ENC_START, 8'h00);
        reg_rd(`ADDR_ENC_LENGTH, 8'h00);
        reg_rd(16'h2010, 8'h00);
        reg_wr(`ADDR_PUSH_DATA, 8'hA1);
        reg_wr(`ADDR_PUSH_DATA, 8'hA2);
        reg_wr(`ADDR_PUSH_DATA, 8'hA3);
        reg_rd(`ADDR_WR_PTR_LOW, 8'h03);
        reg_rd(`ADDR_BYTE_COUNT, 8'h03);
        reg_rd(`ADDR_STATE, 8'h00);
        fetch(9'h001, 1'b0, 8'hA2);
        fetch(9'h000, 1'b1, 8'hA1);
        reg_rd(`ADDR_RD_PTR_LOW, 8'h01);
        for (int i = 0; i < 254; i++) dma_push(i[7:0]);
        reg_rd(`ADDR_STATE, 8'h82);
        reg_rd(`ADDR_WR_PTR_LOW, 8'h01);
        check("dma ready full", dma_ready, 1'b0);
        fetch(9'h100, 1'b0, 8'hFD);
        reg_wr(`ADDR_CONTROL, 8'h07);
        reg_rd(`ADDR_STATE, 8'h01);
        reg_rd(`ADDR_RD_PTR_LOW, 8'h00);
        reg_rd(`ADDR_BYTE_COUNT, 8'h00);
        reg_rd(`ADDR_CONTROL, 8'h06);
        reg_wr(`ADDR_STATE, 8'h80);
        reg_rd(`ADDR_STATE, 8'h82);
        reg_wr(`ADDR_STATE, 8'hC0);
        reg_rd(`ADDR_STATE, 8'hC1);
        reg_wr(`ADDR_CONTROL, 8'h04);
        reg_wr(`ADDR_PUSH_DATA, 8'h5A);
        reg_rd(`ADDR_WR_PTR_LOW, 8'h00);
        check("dma ready off", dma_ready, 1'b0);
        reg_wr(`ADDR_CONTROL, 8'h06);
        reg_wr(`ADDR_ENC_START, 8'h12);
        reg_wr(`ADDR_ENC_LENGTH, 8'h34);
        reg_rd(`ADDR_ENC_START, 8'h12);
        reg_rd(`ADDR_ENC_LENGTH, 8'h34);
        frame_load(8'h40, 8'h11);
        reg_rd(`ADDR_ENC_START, 8'h40);
        reg_rd(`ADDR_ENC_LENGTH, 8'h11);
        reg_wr(`ADDR_CONTROL, 8'h02);
        frame_load(8'h60, 8'h22);
        reg_rd(`ADDR_ENC_START, 8'h40);
        check("window start", cmd.start, 8'h40);
        check("window length", cmd.length, 8'h11);
        reg_rd(`ADDR_REMAINING, 8'h11);
        @(posedge clk);
        #1 rew = 1'b1;
        rew_data = 8'h55;
        @(posedge clk);
        #1 rew = 1'b0;
        fetch(9'h040, 1'b0, 8'h55);
        cipher(8'h01, KEY_A, NON_T);
        check("tx nonce use", cmd.use_tx_nonce, 1'b1);
        delay = 8'h14;
        cipher(8'h07, KEY_B, NON_R);
        check("rx nonce use", cmd.use_tx_nonce, 1'b0);
        reg_wr(`ADDR_CONTROL, 8'h03);
        reg_rd(`ADDR_REMAINING, 8'h00);
        conclude();
    end
endmodule : tx_frame_fifo_tb
